// [include/aop_pkg.sv]
// Constants, pin bundle and sample types for the converter output port
package aop_pkg;
   localparam int AOP_WORD_W = 16;
   localparam int AOP_LATENCY = 7;
   localparam int AOP_MSB = 15;
   localparam int AOP_LSB = 0;
   localparam int AOP_GAIN_W = 11;
   localparam int AOP_RANGE_W = 12;
   // Front-end gain in thousandths and input span in millivolts peak-to-peak
   localparam logic [10:0] AOP_GAIN_UNITY = 11'h3e8;
   localparam logic [10:0] AOP_GAIN_HIGH = 11'h5dc;
   localparam logic [11:0] AOP_RANGE_WIDE = 12'h9c4;
   localparam logic [11:0] AOP_RANGE_NARROW = 12'h683;

   // Four sensed levels of the format pin, ground upward
   typedef enum logic [1:0] {
      AOP_MODE_OB_NODCS,
      AOP_MODE_OB_DCS,
      AOP_MODE_TC_DCS,
      AOP_MODE_TC_FULL
   } aop_mode_e;

   typedef struct packed {
      logic overflow;
      logic [AOP_WORD_W-1:0] word;
   } aop_sample_s;

   typedef struct packed {
      logic sampleClk;
      aop_sample_s sample;
      logic powerDown;
      logic dither;
      aop_mode_e mode;
      logic scramble;
      logic gainHigh;
      logic outputEnableN;
   } aop_pins_s;

   localparam aop_sample_s AOP_SAMPLE_RST = '{overflow: 1'b0, word: 16'h0000};
   // Outputs disabled and analog powered down until pins are seen
   localparam aop_pins_s AOP_PINS_RST = '{
      sampleClk: 1'b0, sample: AOP_SAMPLE_RST, powerDown: 1'b1, dither: 1'b0,
      mode: AOP_MODE_OB_NODCS, scramble: 1'b0, gainHigh: 1'b0, outputEnableN: 1'b1};
endpackage

// [rtl/aop_adc_output_port.sv]
// Digital output port and mode pins of a 16-bit pipelined sampling converter
`timescale 1ns/100ps
// Contract
// - Sample held on sample-clock falling edge; capture may use its rising edge.
// - Power-down high stops analog and floats all digital outputs.
// - Dither applies only while dither enable is high.
// - Result is a 16-bit parallel word, bit fifteen most significant.
// - Complementary data-valid strobes rise and fall once per sample period.
// - Overflow flag high when current sample exceeded range either way.
// - Output enable low drives outputs; high floats them.
// - Format pin level selects offset binary or two's complement and stabilizer.
// - Scramble select high XORs bits one to fifteen with bit zero.
// - Gain select low gives unity and 2.5 V span; high gives 1.5, 1.667 V.
// - Result appears seven sample-clock cycles after the sample is taken.
module aop_adc_output_port
   import aop_pkg::*;
#(
   // Sample-clock periods from capture to output word
   parameter int LATENCY = AOP_LATENCY
)
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic sampleClk,
   input aop_pkg::aop_sample_s rawSample,
   input wire logic power_down_pin,
   input wire logic dither_enable_pin,
   input aop_pkg::aop_mode_e formatModeLevel,
   input wire logic output_scramble_select,
   input wire logic front_gain_select,
   input wire logic outputEnableN,
   output logic [aop_pkg::AOP_WORD_W-1:0] sample_word,
   output logic range_overflow_flag,
   output logic data_valid_strobe,
   output logic data_valid_strobe_inv,
   output logic digitalOutEn,
   output logic analogPowerDown,
   output logic ditherActive,
   output logic dutyStabilizerOn,
   output logic [aop_pkg::AOP_GAIN_W-1:0] frontGainMilli,
   output logic [aop_pkg::AOP_RANGE_W-1:0] inputRangeMv
);
   import aop_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchroniser
   aop_pins_s pinsAsync;
   aop_pins_s syncA_r;
   aop_pins_s syncB_r;
   logic clkPrev_r;

   assign pinsAsync = '{sampleClk: sampleClk, sample: rawSample, powerDown: power_down_pin,
      dither: dither_enable_pin, mode: formatModeLevel, scramble: output_scramble_select,
      gainHigh: front_gain_select, outputEnableN: outputEnableN};

   // The word rides the same two flops as the clock, so it must be steady across the fall
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         syncA_r <= AOP_PINS_RST;
         syncB_r <= AOP_PINS_RST;
         clkPrev_r <= 1'b0;
      end else begin
         syncA_r <= pinsAsync;
         syncB_r <= syncA_r;
         clkPrev_r <= syncB_r.sampleClk;
      end
   end

   // Hold phase starts on the sample clock falling edge
   wire sampleFall = clkPrev_r & ~syncB_r.sampleClk;

   ////////////////////////////////////////////////////////////////////////////
   // Latency pipeline, one stage per sample clock
   aop_sample_s pipe_r [LATENCY];

   genvar gi;
   generate
      for (gi = 0; gi < LATENCY; gi++) begin : gStage
         aop_sample_s stageIn;
         if (gi == 0) begin : gFirst
            assign stageIn = syncB_r.sample;
         end else begin : gNext
            assign stageIn = pipe_r[gi-1];
         end
         always_ff @(posedge clock) begin
            if (sys_rst) begin
               pipe_r[gi] <= AOP_SAMPLE_RST;
            end else if (sampleFall) begin
               pipe_r[gi] <= stageIn;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Output format and scrambling
   wire twosComp = (syncB_r.mode == AOP_MODE_TC_DCS) || (syncB_r.mode == AOP_MODE_TC_FULL);
   wire [AOP_WORD_W-1:0] lastWord = pipe_r[LATENCY-1].word;
   wire msbOut = lastWord[AOP_MSB] ^ twosComp;
   wire [AOP_WORD_W-1:0] fmtWord = {msbOut, lastWord[AOP_MSB-1:0]};
   wire [AOP_WORD_W-1:0] scrMask = {{(AOP_WORD_W-1){fmtWord[AOP_LSB]}}, 1'b0};
   wire [AOP_WORD_W-1:0] wordNxt = syncB_r.scramble ? (fmtWord ^ scrMask) : fmtWord;
   wire outEnNxt = ~syncB_r.powerDown & ~syncB_r.outputEnableN;

   logic [AOP_WORD_W-1:0] sampleWord_r;
   logic overflow_r;
   logic strobe_r;
   logic strobeInv_r;
   logic outEn_r;
   logic powerDown_r;
   logic dither_r;
   logic stabilizer_r;
   logic [AOP_GAIN_W-1:0] gain_r;
   logic [AOP_RANGE_W-1:0] range_r;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sampleWord_r <= AOP_SAMPLE_RST.word;
         overflow_r <= AOP_SAMPLE_RST.overflow;
      end else if (sampleFall) begin
         sampleWord_r <= wordNxt;
         overflow_r <= pipe_r[LATENCY-1].overflow;
      end
   end

   // Data changes near the falling edge, so the strobe falls at the rising edge
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         strobe_r <= 1'b1;
         strobeInv_r <= 1'b0;
      end else begin
         strobe_r <= ~syncB_r.sampleClk;
         strobeInv_r <= syncB_r.sampleClk;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         outEn_r <= 1'b0;
         powerDown_r <= 1'b1;
         dither_r <= 1'b0;
         stabilizer_r <= 1'b0;
         gain_r <= AOP_GAIN_UNITY;
         range_r <= AOP_RANGE_WIDE;
      end else begin
         outEn_r <= outEnNxt;
         powerDown_r <= syncB_r.powerDown;
         dither_r <= syncB_r.dither;
         stabilizer_r <= syncB_r.mode != AOP_MODE_OB_NODCS;
         gain_r <= syncB_r.gainHigh ? AOP_GAIN_HIGH : AOP_GAIN_UNITY;
         range_r <= syncB_r.gainHigh ? AOP_RANGE_NARROW : AOP_RANGE_WIDE;
      end
   end

   assign sample_word = sampleWord_r;
   assign range_overflow_flag = overflow_r;
   assign data_valid_strobe = strobe_r;
   assign data_valid_strobe_inv = strobeInv_r;
   assign digitalOutEn = outEn_r;
   assign analogPowerDown = powerDown_r;
   assign ditherActive = dither_r;
   assign dutyStabilizerOn = stabilizer_r;
   assign frontGainMilli = gain_r;
   assign inputRangeMv = range_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   a_pipe_capture: assert property (sampleFall |=> pipe_r[0] == $past(syncB_r.sample))
      else $error("first stage missed the held sample");
   a_pipe_hold: assert property (!sampleFall |=> $stable(pipe_r[0]))
      else $error("first stage moved without a sample edge");
   a_latency_tail: assert property (sampleFall |=>
         pipe_r[LATENCY-1] == $past(pipe_r[LATENCY-2]))
      else $error("pipeline tail did not advance");
   a_word_hold: assert property (!sampleFall |=>
         $stable(sample_word) && $stable(range_overflow_flag))
      else $error("output word changed without a sample edge");
   a_overflow_out: assert property (sampleFall |=>
         range_overflow_flag == $past(pipe_r[LATENCY-1].overflow))
      else $error("overflow flag does not follow its sample");
   a_format_msb: assert property (sampleFall ##1 !$past(syncB_r.scramble)
         |-> sample_word[AOP_MSB] == ($past(lastWord[AOP_MSB], 1) ^ $past(twosComp)))
      else $error("most significant bit encoding wrong");
   a_offset_msb: assert property (sampleFall ##1 !$past(syncB_r.scramble) &&
         ($past(syncB_r.mode) == AOP_MODE_OB_NODCS || $past(syncB_r.mode) == AOP_MODE_OB_DCS)
         |-> sample_word[AOP_MSB] == $past(lastWord[AOP_MSB]))
      else $error("offset binary word altered");
   a_scramble_decode: assert property (sampleFall |=>
         ((sample_word ^ ($past(syncB_r.scramble) ? {{(AOP_WORD_W-1){sample_word[AOP_LSB]}}, 1'b0}
         : '0)) == $past(fmtWord)))
      else $error("scrambled word does not decode to the formatted word");
   a_strobe_pair: assert property (data_valid_strobe == !data_valid_strobe_inv)
      else $error("data-valid strobes not complementary");
   a_strobe_edge: assert property (sampleFall |=> ##1
         $rose(data_valid_strobe) || data_valid_strobe)
      else $error("strobe not high after sample clock fell");
   a_strobe_rise: assert property (sampleFall |=> $rose(data_valid_strobe))
      else $error("strobe did not rise with the new word");
   a_word_settled: assert property ($fell(data_valid_strobe) |-> $stable(sample_word))
      else $error("word moved at the capture edge");
   a_out_float: assert property (syncB_r.powerDown || syncB_r.outputEnableN |=>
         !digitalOutEn)
      else $error("outputs driven while disabled");
   a_out_drive: assert property (!syncB_r.powerDown && !syncB_r.outputEnableN |=>
         digitalOutEn)
      else $error("outputs floating while enabled");
   a_pd_float: assert property (analogPowerDown |-> !digitalOutEn)
      else $error("outputs driven while powered down");
   a_dither_gate: assert property (ditherActive |-> $past(syncB_r.dither))
      else $error("dither active without enable");
   a_dither_follow: assert property ($past(syncB_r.dither) |-> ditherActive)
      else $error("dither enable ignored");
   a_stabilizer_mode: assert property (##1
         dutyStabilizerOn == ($past(syncB_r.mode) != AOP_MODE_OB_NODCS))
      else $error("stabilizer does not match format level");
   a_gain_range: assert property (
         (frontGainMilli == AOP_GAIN_HIGH) == (inputRangeMv == AOP_RANGE_NARROW))
      else $error("gain and range disagree");
   a_gain_select: assert property ($past(syncB_r.gainHigh) |->
         frontGainMilli == AOP_GAIN_HIGH && inputRangeMv == AOP_RANGE_NARROW)
      else $error("high gain pin not applied");

   c_scrambled_word: cover property (sampleFall ##1 syncB_r.scramble && sample_word[AOP_LSB]);
   c_twos_comp: cover property (sampleFall && twosComp ##1 digitalOutEn);
   c_overflow: cover property ($rose(range_overflow_flag));
   c_power_down: cover property ($fell(digitalOutEn) && analogPowerDown);
endmodule

// [tb/aop_capture_model.sv]
// Far-side capture logic: latches on the data-valid fall and undoes scrambling
`timescale 1ns/100ps
module aop_capture_model
   import aop_pkg::*;
(
   input wire logic [aop_pkg::AOP_WORD_W-1:0] sample_word,
   input wire logic data_valid_strobe,
   input wire logic output_scramble_select,
   output logic [aop_pkg::AOP_WORD_W-1:0] capWord,
   output int capCount
);
   int cnt = 0;
   assign capCount = cnt;
   always @(negedge data_valid_strobe) begin
      capWord = output_scramble_select ? sample_word ^ {{15{sample_word[0]}}, 1'b0}
         : sample_word;
      cnt = cnt + 1;
   end
endmodule

// [tb/aop_adc_output_port_tb.sv]
// Self-checking bench for the converter output port
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("mismatch %s exp %h got %h", nm, e, g); end end
module aop_adc_output_port_tb;
   import aop_pkg::*;
   logic clock = 1'b0, sys_rst = 1'b1, sampleClk = 1'b1, power_down_pin = 1'b0;
   logic dither_enable_pin = 1'b0, output_scramble_select = 1'b0, front_gain_select = 1'b0;
   logic outputEnableN = 1'b0, chk = 1'b0;
   logic [15:0] lfsr = 16'h64e9;
   aop_sample_s raw = '0;
   aop_sample_s hist[64];
   aop_mode_e mode = AOP_MODE_OB_NODCS;
   int n_mismatch = 0, cmp_count = 0, nFall = 0, phase = 0, capCount, expIdx;
   logic [15:0] sample_word, capWord, expW;
   logic range_overflow_flag, data_valid_strobe, data_valid_strobe_inv, digitalOutEn;
   logic analogPowerDown, ditherActive, dutyStabilizerOn;
   logic [10:0] frontGainMilli;
   logic [11:0] inputRangeMv;
   aop_adc_output_port dut (.clock(clock), .sys_rst(sys_rst), .sampleClk(sampleClk),
      .rawSample(raw), .power_down_pin(power_down_pin), .dither_enable_pin(dither_enable_pin),
      .formatModeLevel(mode), .output_scramble_select(output_scramble_select),
      .front_gain_select(front_gain_select), .outputEnableN(outputEnableN),
      .sample_word(sample_word), .range_overflow_flag(range_overflow_flag),
      .data_valid_strobe(data_valid_strobe), .data_valid_strobe_inv(data_valid_strobe_inv),
      .digitalOutEn(digitalOutEn), .analogPowerDown(analogPowerDown),
      .ditherActive(ditherActive), .dutyStabilizerOn(dutyStabilizerOn),
      .frontGainMilli(frontGainMilli), .inputRangeMv(inputRangeMv));
   aop_capture_model partner (.sample_word(sample_word), .data_valid_strobe(data_valid_strobe),
      .output_scramble_select(output_scramble_select), .capWord(capWord), .capCount(capCount));
   function automatic logic [15:0] expWord(aop_sample_s s, aop_mode_e m, logic sc);
      logic [15:0] w;
      w = s.word ^ {m >= AOP_MODE_TC_DCS, 15'h0000};
      if (sc) begin
         w[15:1] = w[15:1] ^ {15{w[0]}};
      end
      return w;
   endfunction
   function automatic logic [15:0] lfsrNext(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   initial begin
      forever #5 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Sample clock of 160 ns; sample held at its fall, random words with corner cases
   always @(posedge clock) begin
      phase <= (phase == 15) ? 0 : phase + 1;
      if (phase == 7) begin
         sampleClk <= 1'b0;
         hist[nFall % 64] <= raw;
         nFall <= nFall + 1;
      end
      if (phase == 15) begin
         sampleClk <= 1'b1;
         lfsr <= lfsrNext(lfsr);
         raw <= (nFall % 8 == 0) ? {1'b1, 16'hffff} : (nFall % 8 == 4) ? 17'h00001
            : {lfsr[3], lfsr};
      end
   end
   always @(negedge data_valid_strobe) begin
      if (chk) begin
         #1;
         // Word on show left the pipe at the last fall, seven falls after its capture
         expIdx = (nFall - 8) % 64;
         expW = expWord(hist[expIdx], mode, output_scramble_select);
         `CHK("sample_word", expW, sample_word)
         `CHK("overflow", hist[expIdx].overflow, range_overflow_flag)
         `CHK("strobe_pair", ~data_valid_strobe, data_valid_strobe_inv)
         `CHK("capture", expWord(hist[expIdx], mode, 1'b0), capWord)
      end
   end
   task print_verdict();
      $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task waitCaps(input int n);
      int t0;
      t0 = capCount;
      for (int i = 0; i < 2000; i++) begin
         @(posedge clock);
         if (capCount >= t0 + n) return;
      end
      n_mismatch++;
      $display("mismatch capture_wait exp %0d got %0d", n, capCount - t0);
      print_verdict();
   endtask
   initial begin
      repeat (12) @(posedge clock);
      `CHK("reset_pd", 1'b1, analogPowerDown)
      sys_rst <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         @(posedge clock);
         {power_down_pin, outputEnableN, dither_enable_pin, front_gain_select} <= i[3:0];
         repeat (4) @(posedge clock);
         `CHK("out_en", ~i[3] & ~i[2], digitalOutEn)
         `CHK("power_down", i[3], analogPowerDown)
         `CHK("dither", i[1], ditherActive)
         `CHK("gain", i[0] ? AOP_GAIN_HIGH : AOP_GAIN_UNITY, frontGainMilli)
         `CHK("range", i[0] ? AOP_RANGE_NARROW : AOP_RANGE_WIDE, inputRangeMv)
      end
      {power_down_pin, outputEnableN} <= 2'b00;
      for (int k = 0; k < 8; k++) begin
         chk <= 1'b0;
         mode <= aop_mode_e'(k[1:0]);
         output_scramble_select <= k[2];
         repeat (40) @(posedge clock);
         `CHK("stabilizer", k[1:0] != 2'b00, dutyStabilizerOn)
         chk <= 1'b1;
         waitCaps(6);
      end
      print_verdict();
   end
endmodule
